// >>> verilog/ata_device_end.sv
// Drive end: decodes unlock, seek and queued send, keeps lock state.
// Assumes stored passwords and security setting come from the user side.
`timescale 1ns/1ps
module ata_device_end
    import ata_cmd_pkg::*;
#(
    parameter int PW_BITS = 256
)(
    input  wire logic               i_mclk,
    input  wire logic               i_rstn,
    ata_cmd_if.device_mp            bus,
    input  wire logic [PW_BITS-1:0] i_master_pw,
    input  wire logic [PW_BITS-1:0] i_user_pw,
    input  wire logic               i_sec_enabled,
    input  wire logic               i_sec_max_level,
    input  wire logic               i_seek_done,
    input  wire logic               i_seek_fail,
    input  wire logic               i_seek_idnf,
    input  wire logic               i_queued_done,
    input  wire logic               i_queued_fail,
    output logic                    o_locked,
    output logic [2:0]              o_attempts_left,
    output logic                    o_seek_start,
    output logic                    o_seek_lba,
    output logic [27:0]             o_seek_target,
    output logic                    o_queued_start
);
    import ata_cmd_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_RECV, S_JUDGE, S_SEEK, S_QUEUED} dev_state_t;

    dev_state_t  state;
    dev_state_t  next_state;
    logic [7:0]  word_cnt;
    logic        drq;
    logic        busy;
    logic        err;
    logic        seek_complete;
    logic        done;
    logic [7:0]  error;
    logic        is_master;
    logic        mismatch;
    logic [7:0]  ret_sect;
    logic [7:0]  ret_cyl_lo;
    logic [7:0]  ret_cyl_hi;
    logic [3:0]  ret_head;
    logic        fin;
    logic        fin_abort;
    logic        fin_idnf;
    logic        dec_attempt;
    logic        do_unlock;

    assign bus.status     = {busy, 1'b1, 1'b0, seek_complete, drq, 1'b0, 1'b0, err};
    assign bus.error      = error;
    assign bus.done       = done;
    assign bus.ret_sect   = ret_sect;
    assign bus.ret_cyl_lo = ret_cyl_lo;
    assign bus.ret_cyl_hi = ret_cyl_hi;
    assign bus.ret_head   = ret_head;

    pw_compare #(
        .W (16),
        .N (PW_BITS / 16)
    ) u_cmp (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_clear    (state == S_IDLE),
        .i_valid    (state == S_RECV && bus.wr_valid),
        .i_index    (word_cnt),
        .i_word     (bus.wr_data),
        .i_ref      (is_master ? i_master_pw : i_user_pw), // [R6] [R8]
        .o_mismatch (mismatch)
    );

    // Command decode and completion
    always_comb
    begin
        next_state  = state;
        fin         = 1'b0;
        fin_abort   = 1'b0;
        fin_idnf    = 1'b0;
        dec_attempt = 1'b0;
        do_unlock   = 1'b0;
        case (state)
            S_IDLE:
            begin
                if (bus.cmd_strobe)
                begin
                    if (bus.cmd_code == CMD_UNLOCK) // [R1]
                    begin
                        if (o_attempts_left == 3'h0)
                        begin
                            fin       = 1'b1; // [R11]
                            fin_abort = 1'b1;
                        end
                        else
                            next_state = S_RECV; // [R4]
                    end
                    else if (bus.cmd_code[7:4] == CMD_SEEK_NIB) // [R14]
                        next_state = S_SEEK;
                    else if (bus.cmd_code == CMD_QUEUED) // [R19]
                        next_state = S_QUEUED;
                    else
                    begin
                        fin       = 1'b1;
                        fin_abort = 1'b1;
                    end
                end
            end
            S_RECV:
            begin
                if (bus.wr_valid && word_cnt == SECTOR_LAST)
                    next_state = S_JUDGE; // [R4]
            end
            S_JUDGE:
            begin
                fin        = 1'b1;
                next_state = S_IDLE;
                if (is_master && i_sec_max_level)
                    fin_abort = 1'b1; // [R7] [R20]
                else if (!is_master && !i_sec_enabled)
                    fin_abort = 1'b1; // [R12]
                else if (mismatch)
                begin
                    fin_abort   = 1'b1; // [R9] [R13]
                    dec_attempt = 1'b1;
                end
                else
                    do_unlock = 1'b1; // [R2]
            end
            S_SEEK:
            begin
                if (i_seek_done)
                begin
                    fin        = 1'b1;
                    next_state = S_IDLE;
                    fin_idnf   = i_seek_fail && i_seek_idnf; // [R22]
                    fin_abort  = i_seek_fail && !i_seek_idnf; // [R22]
                end
            end
            S_QUEUED:
            begin
                if (i_queued_done)
                begin
                    fin        = 1'b1;
                    next_state = S_IDLE;
                    fin_abort  = i_queued_fail;
                end
            end
            default:
                next_state = S_IDLE;
        endcase
        if (fin)
            next_state = S_IDLE;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // Sector word counter and type capture
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            word_cnt  <= 8'h00;
            is_master <= 1'b0;
        end
        else if (state != S_RECV)
            word_cnt <= 8'h00;
        else if (bus.wr_valid)
        begin
            word_cnt <= word_cnt + 8'h01;
            if (word_cnt == 8'h00)
                is_master <= bus.wr_data[TYPE_BIT]; // [R5]
        end
    end

    // Handshake and status bits
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            busy          <= 1'b0;
            drq           <= 1'b0;
            done          <= 1'b0;
            err           <= 1'b0;
            error         <= 8'h00;
            seek_complete <= 1'b1;
        end
        else
        begin
            done <= fin;
            busy <= (next_state != S_IDLE) && (next_state != S_RECV);
            drq  <= (next_state == S_RECV);
            if (state == S_IDLE && bus.cmd_strobe)
            begin
                err   <= 1'b0;
                error <= 8'h00;
            end
            if (fin)
            begin
                err                  <= fin_abort || fin_idnf; // [R22]
                error[ERR_ABORT_BIT] <= fin_abort;
                error[ERR_IDNF_BIT]  <= fin_idnf;
            end
            if (next_state == S_SEEK && state == S_IDLE)
                seek_complete <= 1'b0;
            else if (state == S_SEEK && fin)
                seek_complete <= 1'b1;
        end
    end

    // Lock state and attempt counter
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            o_locked        <= i_sec_enabled; // [R3]
            o_attempts_left <= ATTEMPTS_INIT; // [R10] [R21]
        end
        else
        begin
            if (do_unlock)
                o_locked <= 1'b0; // [R2]
            if (dec_attempt && o_attempts_left != 3'h0)
                o_attempts_left <= o_attempts_left - 3'h1; // [R9] [R10]
        end
    end

    // Seek launch and address return
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            o_seek_start  <= 1'b0;
            o_seek_lba    <= 1'b0;
            o_seek_target <= 28'h0000000;
            ret_sect      <= 8'h00;
            ret_cyl_lo    <= 8'h00;
            ret_cyl_hi    <= 8'h00;
            ret_head      <= 4'h0;
        end
        else
        begin
            o_seek_start <= (state == S_IDLE) && (next_state == S_SEEK); // [R15]
            if (state == S_IDLE && next_state == S_SEEK)
            begin
                o_seek_lba    <= bus.dev_head[LBA_SEL_BIT];
                o_seek_target <= {bus.dev_head[3:0], bus.cyl_hi, bus.cyl_lo, bus.sect_num}; // [R16] [R17]
            end
            if (state == S_SEEK && fin)
            begin
                ret_sect   <= o_seek_target[7:0]; // [R18]
                ret_cyl_lo <= o_seek_target[15:8];
                ret_cyl_hi <= o_seek_target[23:16];
                ret_head   <= o_seek_target[27:24];
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
            o_queued_start <= 1'b0;
        else
            o_queued_start <= (state == S_IDLE) && (next_state == S_QUEUED); // [R19]
    end
endmodule

// >>> verilog/ata_cmd_pkg.sv
// Constants for the unlock, seek and queued-send command path.
// Assumes one 200 MHz clock shared by both ends.
// Function
// [R1] Code F2h decodes as password unlock
// [R2] Password match clears the locked state
// [R3] Reset returns to locked, password kept; code locks at reset only while i_sec_enabled is set
// [R4] Exactly one password sector precedes comparison
// [R5] Word 0 bit 0 type; words 1-16 password
// [R6] Master type, high level: compare master
// [R7] Master type, maximum level: reject unlock
// [R8] User type compares stored user password
// [R9] Mismatch aborts and decrements attempt counter
// [R10] Attempt counter starts at five
// [R11] Counter zero rejects protected commands until reset
// [R12] Security disabled, user type: abort
// [R13] Post-sector abort only means password mismatch; code also aborts after the sector for [R7] and [R12]
// [R14] Upper nibble 0111 decodes as seek
// [R15] Seek positions track/head, unformatted medium fine
// [R16] Block mode target from sector, cylinders, head
// [R17] Track mode: cylinder registers plus head field
// [R18] Block-mode completion returns current 28-bit address
// [R19] Code 64h decodes as queued send
// [R20] Level bit: zero high, one maximum
// [R21] Reset restores attempt counter to five
// [R22] Seek error sets status error, abort/not-found
package ata_cmd_pkg;
    localparam logic [7:0]  CMD_UNLOCK     = 8'hF2;
    localparam logic [3:0]  CMD_SEEK_NIB   = 4'h7;
    localparam logic [7:0]  CMD_QUEUED     = 8'h64;
    localparam logic [2:0]  ATTEMPTS_INIT  = 3'h5;
    localparam logic [7:0]  SECTOR_LAST    = 8'hFF;
    localparam logic [7:0]  PW_FIRST       = 8'h01;
    localparam logic [7:0]  PW_LAST        = 8'h10;
    localparam int          TYPE_BIT       = 0;
    localparam int          LBA_SEL_BIT    = 6;
    localparam int          ERR_ABORT_BIT  = 2;
    localparam int          ERR_IDNF_BIT   = 4;
    localparam logic [7:0]  HOST_CMD       = 8'h00;
    localparam logic [7:0]  HOST_TASKFILE  = 8'h04;
    localparam logic [7:0]  HOST_PWTYPE    = 8'h08;
    localparam logic [7:0]  HOST_STATUS    = 8'h0C;
    localparam logic [7:0]  HOST_RESULT    = 8'h10;
    localparam logic [7:0]  HOST_PW_BASE   = 8'h40;
    localparam int          STAT_BUSY_BIT  = 16;
    localparam int          STAT_DONE_BIT  = 17;
endpackage

// >>> verilog/ata_cmd_if.sv
// Command block link between host adapter and drive.
// Assumes both ends clocked by the same i_mclk.
`timescale 1ns/1ps
interface ata_cmd_if;
    logic        cmd_strobe;
    logic [7:0]  cmd_code;
    logic [7:0]  sect_num;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [7:0]  dev_head;
    logic [15:0] wr_data;
    logic        wr_valid;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [7:0]  ret_sect;
    logic [7:0]  ret_cyl_lo;
    logic [7:0]  ret_cyl_hi;
    logic [3:0]  ret_head;
    logic        done;

    modport host_mp (
        output cmd_strobe, cmd_code, sect_num, cyl_lo, cyl_hi, dev_head, wr_data, wr_valid,
        input  status, error, ret_sect, ret_cyl_lo, ret_cyl_hi, ret_head, done
    );
    modport device_mp (
        input  cmd_strobe, cmd_code, sect_num, cyl_lo, cyl_hi, dev_head, wr_data, wr_valid,
        output status, error, ret_sect, ret_cyl_lo, ret_cyl_hi, ret_head, done
    );
endinterface

// >>> verilog/pw_compare.sv
// Word-by-word password comparator with a sticky mismatch flag.
// Assumes the caller clears it before each sector.
`timescale 1ns/1ps
module pw_compare
    import ata_cmd_pkg::*;
#(
    parameter int W = 16,
    parameter int N = 16
)(
    input  wire logic           i_mclk,
    input  wire logic           i_rstn,
    input  wire logic           i_clear,
    input  wire logic           i_valid,
    input  wire logic [7:0]     i_index,
    input  wire logic [W-1:0]   i_word,
    input  wire logic [W*N-1:0] i_ref,
    output logic                o_mismatch
);
    logic [7:0] slot;

    always_comb
    begin
        slot = i_index - PW_FIRST;
    end

    // Only words 1..16 carry the password
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn || i_clear)
            o_mismatch <= 1'b0;
        else if (i_valid && i_index >= PW_FIRST && i_index <= PW_LAST &&
                 i_word != i_ref[slot[3:0]*W +: W])
            o_mismatch <= 1'b1; // [R5]
    end
endmodule

// >>> verilog/ata_host_end.sv
// Host adapter end: software registers issue commands and stream the password sector.
// Assumes a plain one-cycle register port from software.
`timescale 1ns/1ps
module ata_host_end
    import ata_cmd_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    ata_cmd_if.host_mp       bus
);
    import ata_cmd_pkg::*;

    logic [15:0] pw_word [16];
    logic [31:0] taskfile;
    logic        pw_type;
    logic        in_flight;
    logic        done_seen;
    logic        sending;
    logic [7:0]  send_cnt;
    logic [8:0]  sent_total;

    // Password buffer words
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_pw
            always_ff @(posedge i_mclk)
            begin
                if (!i_rstn)
                    pw_word[g] <= 16'h0000;
                else if (i_wr && i_addr == HOST_PW_BASE + 8'(4 * g))
                    pw_word[g] <= i_wdata[15:0]; // [R5]
            end
        end
    endgenerate

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            taskfile <= 32'h00000000;
            pw_type  <= 1'b0;
        end
        else if (i_wr && i_addr == HOST_TASKFILE)
            taskfile <= i_wdata;
        else if (i_wr && i_addr == HOST_PWTYPE)
            pw_type <= i_wdata[0];
    end

    // Command issue
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            bus.cmd_strobe <= 1'b0;
            bus.cmd_code   <= 8'h00;
            bus.sect_num   <= 8'h00;
            bus.cyl_lo     <= 8'h00;
            bus.cyl_hi     <= 8'h00;
            bus.dev_head   <= 8'h00;
            in_flight      <= 1'b0;
        end
        else
        begin
            bus.cmd_strobe <= 1'b0;
            if (i_wr && i_addr == HOST_CMD && !in_flight)
            begin
                bus.cmd_strobe <= 1'b1; // [R1] [R14] [R19]
                bus.cmd_code   <= i_wdata[7:0];
                bus.sect_num   <= taskfile[7:0]; // [R16] [R17]
                bus.cyl_lo     <= taskfile[15:8];
                bus.cyl_hi     <= taskfile[23:16];
                bus.dev_head   <= taskfile[31:24];
                in_flight      <= 1'b1;
            end
            else if (bus.done)
                in_flight <= 1'b0;
        end
    end

    // Password sector stream, one word per cycle while data is requested
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            sending      <= 1'b0;
            send_cnt     <= 8'h00;
            sent_total   <= 9'h000;
            bus.wr_valid <= 1'b0;
            bus.wr_data  <= 16'h0000;
        end
        else
        begin
            bus.wr_valid <= 1'b0;
            if (bus.cmd_strobe)
            begin
                sent_total <= 9'h000;
                send_cnt   <= 8'h00;
            end
            else if (bus.status[3] && sent_total[8] == 1'b0 && !sending)
                sending <= 1'b1;
            else if (sending)
            begin
                bus.wr_valid <= 1'b1; // [R4]
                if (send_cnt == 8'h00)
                    bus.wr_data <= {15'h0000, pw_type}; // [R5]
                else if (send_cnt >= PW_FIRST && send_cnt <= PW_LAST)
                    bus.wr_data <= pw_word[4'(send_cnt - PW_FIRST)];
                else
                    bus.wr_data <= 16'h0000;
                send_cnt   <= send_cnt + 8'h01;
                sent_total <= sent_total + 9'h001;
                if (send_cnt == SECTOR_LAST)
                    sending <= 1'b0;
            end
        end
    end

    // Read port and sticky completion flag
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            o_rdata   <= 32'h00000000;
            done_seen <= 1'b0;
        end
        else
        begin
            o_rdata <= 32'h00000000;
            if (bus.done)
                done_seen <= 1'b1;
            else if (i_rd && i_addr == HOST_STATUS)
                done_seen <= 1'b0;
            if (i_rd)
            begin
                case (i_addr)
                    HOST_TASKFILE: o_rdata <= taskfile;
                    HOST_PWTYPE:   o_rdata <= {31'h00000000, pw_type};
                    HOST_STATUS:   o_rdata <= {14'h0000, done_seen, in_flight, bus.error, bus.status};
                    HOST_RESULT:   o_rdata <= {4'h0, bus.ret_head, bus.ret_cyl_hi, bus.ret_cyl_lo, bus.ret_sect};
                    default:       o_rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// >>> bench/ata_link_props.sv
// Checker on the host/drive command link.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ata_link_props
(
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       cmd_strobe,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] sect_num,
    input  wire logic [7:0] cyl_lo,
    input  wire logic [7:0] cyl_hi,
    input  wire logic [7:0] dev_head,
    input  wire logic       wr_valid,
    input  wire logic [7:0] status,
    input  wire logic [7:0] error,
    input  wire logic [7:0] ret_sect,
    input  wire logic [7:0] ret_cyl_lo,
    input  wire logic [7:0] ret_cyl_hi,
    input  wire logic [3:0] ret_head,
    input  wire logic       done
);
    import ata_cmd_pkg::*;
    logic [8:0] words;

    // Words taken while the sector is requested
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn || cmd_strobe)
            words <= 9'h000;
        else if (wr_valid && status[3])
            words <= words + 9'h001;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence idle_req;
        cmd_strobe && !status[7] && !status[3];
    endsequence
    sequence unlock_req;
        idle_req ##0 cmd_code == CMD_UNLOCK;
    endsequence
    sequence seek_req;
        idle_req ##0 cmd_code[7:4] == CMD_SEEK_NIB;
    endsequence

    a_unlock_asks_sector: assert property (unlock_req |=> status[3] || done)
        else $error("unlock gave no sector request");
    a_seek_goes_busy: assert property (seek_req |=> status[7] && !status[4])
        else $error("seek not started");
    a_one_sector: assert property ($fell(status[3]) |-> words == 9'h100)
        else $error("sector length wrong");
    a_judge_after_sector: assert property ($fell(status[3]) |=> done)
        else $error("no end after sector");
    a_seek_returns: assert property (done && cmd_code[7:4] == CMD_SEEK_NIB && dev_head[LBA_SEL_BIT]
        |-> {ret_head, ret_cyl_hi, ret_cyl_lo, ret_sect} == {dev_head[3:0], cyl_hi, cyl_lo, sect_num})
        else $error("seek address not returned");
    a_seek_err_code: assert property (done && cmd_code[7:4] == CMD_SEEK_NIB && status[0]
        |-> error[ERR_ABORT_BIT] || error[ERR_IDNF_BIT])
        else $error("seek error without cause");
    a_err_kinds: assert property (done |-> (error & 8'hEB) == 8'h00 && status[0] == (error != 8'h00))
        else $error("bad error code");
    a_done_ends: assert property (done |-> !status[7] ##1 !done)
        else $error("done not a clean pulse");
endmodule

// >>> bench/ata_unlock_seek_commands_tb.sv
// Bench for the unlock, seek and queued-send path, both ends joined.
// Assumes the software register map of the host end.
`timescale 1ns/1ps
module ata_unlock_seek_commands_tb;
    import ata_cmd_pkg::*;
    logic         mclk;
    logic         rstn;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  rdata;
    logic [255:0] master_pw;
    logic [255:0] user_pw;
    logic         sec_en;
    logic         sec_max;
    logic         seek_done;
    logic         seek_fail;
    logic         seek_idnf;
    logic         q_done;
    logic         q_fail;
    logic         locked;
    logic [2:0]   attempts;
    logic         seek_start;
    logic         seek_lba;
    logic [27:0]  target;
    logic         q_start;
    logic         q_seen = 1'b0;
    logic         is_q = 1'b0;
    logic [1:0]   wait_cnt = 2'h0;
    logic [31:0]  st;
    int           n_errors;
    int           checks_done;
    int           cycles = 0;

    ata_cmd_if bus_if();
    ata_host_end i_ata_host_end (.i_mclk(mclk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .bus(bus_if.host_mp));
    ata_device_end i_ata_device_end (.i_mclk(mclk), .i_rstn(rstn), .bus(bus_if.device_mp),
        .i_master_pw(master_pw), .i_user_pw(user_pw), .i_sec_enabled(sec_en), .i_sec_max_level(sec_max),
        .i_seek_done(seek_done), .i_seek_fail(seek_fail), .i_seek_idnf(seek_idnf), .i_queued_done(q_done),
        .i_queued_fail(q_fail), .o_locked(locked), .o_attempts_left(attempts), .o_seek_start(seek_start),
        .o_seek_lba(seek_lba), .o_seek_target(target), .o_queued_start(q_start));
    ata_link_props i_ata_link_props (.i_mclk(mclk), .i_rstn(rstn), .cmd_strobe(bus_if.cmd_strobe),
        .cmd_code(bus_if.cmd_code), .sect_num(bus_if.sect_num), .cyl_lo(bus_if.cyl_lo), .cyl_hi(bus_if.cyl_hi),
        .dev_head(bus_if.dev_head), .wr_valid(bus_if.wr_valid), .status(bus_if.status), .error(bus_if.error),
        .ret_sect(bus_if.ret_sect), .ret_cyl_lo(bus_if.ret_cyl_lo), .ret_cyl_hi(bus_if.ret_cyl_hi),
        .ret_head(bus_if.ret_head), .done(bus_if.done));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Mechanics: seek and queued work end three cycles after start
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (seek_start || q_start)
        begin
            wait_cnt <= 2'h3;
            is_q <= q_start;
        end
        else if (wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
        seek_done <= wait_cnt == 2'h1 && !is_q;
        q_done <= wait_cnt == 2'h1 && is_q;
        if (q_start)
            q_seen <= 1'b1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask

    task automatic run(input logic [7:0] code);
        int i;
        wr_reg(HOST_CMD, {24'h0, code});
        st = 32'h0;
        for (i = 0; i < 400 && st[STAT_DONE_BIT] !== 1'b1; i++)
            rd_reg(HOST_STATUS, st);
        check(st[STAT_DONE_BIT], 1'b1);
    endtask

    task automatic load_pw(input logic [15:0] kind, input logic [15:0] base);
        int i;
        wr_reg(HOST_PWTYPE, {16'h0, kind});
        for (i = 0; i < 16; i++)
            wr_reg(HOST_PW_BASE + 8'(4 * i), {16'h0, base + 16'(i)});
    endtask

    task automatic reset_dut();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        int k;
        {rstn, wr, rd, addr, wdata, sec_max, seek_fail, seek_idnf, q_fail} = '0;
        {n_errors, checks_done} = '0;
        sec_en = 1'b1;
        for (k = 0; k < 16; k++)
        begin
            user_pw[k*16+:16] = 16'h1000 + 16'(k);
            master_pw[k*16+:16] = 16'h2000 + 16'(k);
        end
        reset_dut();
        check({locked, attempts}, {1'b1, ATTEMPTS_INIT});
        rd_reg(HOST_STATUS, st);
        check(st[15:0], 16'h0050);
        rd_reg(8'h20, st);
        check(st, 32'h0);
        wr_reg(HOST_TASKFILE, 32'h4B234567);
        rd_reg(HOST_TASKFILE, st);
        check(st, 32'h4B234567);
        run(8'h7A);
        check({seek_lba, target}, {1'b1, 28'hB234567});
        check({bus_if.ret_head, bus_if.ret_cyl_hi, bus_if.ret_cyl_lo, bus_if.ret_sect}, 28'hB234567);
        check(st[15:0], 16'h0050);
        rd_reg(HOST_RESULT, st);
        check(st, 32'h0B234567);
        wr_reg(HOST_TASKFILE, 32'h05030201);
        seek_fail <= 1'b1;
        for (k = 0; k < 2; k++)
        begin
            seek_idnf <= k == 0;
            run(8'h70);
            check({seek_lba, target}, {1'b0, 28'h5030201});
            check(st[15:0], {(k == 0) ? 8'h10 : 8'h04, 8'h51});
        end
        run(CMD_QUEUED);
        check({q_seen, st[15:8]}, {1'b1, 8'h00});
        q_fail <= 1'b1;
        run(CMD_QUEUED);
        check(st[15:8], 8'h04);
        load_pw(16'h0000, 16'h3000);
        run(CMD_UNLOCK);
        check(st[15:0], 16'h0451);
        check({locked, attempts}, {1'b1, 3'h4});
        sec_max <= 1'b1;
        load_pw(16'h0001, 16'h2000);
        rd_reg(HOST_PWTYPE, st);
        check(st, 32'h00000001);
        run(CMD_UNLOCK);
        check({attempts, locked, st[15:8]}, {3'h4, 1'b1, 8'h04});
        sec_max <= 1'b0;
        run(CMD_UNLOCK);
        check({locked, st[15:0]}, {1'b0, 16'h0050});
        reset_dut();
        check({locked, attempts}, {1'b1, ATTEMPTS_INIT});
        load_pw(16'hFFFE, 16'h1000);
        run(CMD_UNLOCK);
        check({locked, st[15:8]}, {1'b0, 8'h00});
        reset_dut();
        load_pw(16'h0000, 16'h3000);
        for (k = 0; k < 5; k++)
            run(CMD_UNLOCK);
        check(attempts, 3'h0);
        load_pw(16'h0000, 16'h1000);
        run(CMD_UNLOCK);
        check({locked, st[15:8]}, {1'b1, 8'h04});
        sec_en <= 1'b0;
        reset_dut();
        check({locked, attempts}, {1'b0, ATTEMPTS_INIT});
        load_pw(16'h0000, 16'h1000);
        run(CMD_UNLOCK);
        check({attempts, st[15:8]}, {ATTEMPTS_INIT, 8'h04});
        results();
    end
endmodule
